/* File: hdl/tmr_tree_multiplier.sv */
// 16x16 binary-tree multiplier with optional per-stage pipelining
// assumes a classic wishbone master and operand logic in the clk domain
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tmr_tree_multiplier #(
  parameter bit CHIP_RESET_EN = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tmr_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [tmr_pkg::OP_W-1:0] fast_line_a,
  input wire logic [tmr_pkg::OP_W-1:0] fast_line_b,
  input wire logic group_clock_enable_secondary,
  input wire logic group_clear,
  input wire logic group_preset_or_async_load,
  input wire logic chip_wide_reset_n,
  output logic [tmr_pkg::PROD_W-1:0] product_fast,
  output logic [tmr_pkg::PROD_W-1:0] product_local
);
  localparam int L = tmr_pkg::TREE_STAGES;
  localparam int N = tmr_pkg::NODES;
  localparam int W = tmr_pkg::PROD_W;

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        r[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  // one partial product: whole multiplicand gated by one multiplier bit
  function automatic logic [31:0] part_prod(input logic [15:0] a, input logic [15:0] b,
                                            input int j);
    logic [31:0] t;
    t = {16'h0000, a & {16{b[j]}}};
    return t << j;
  endfunction : part_prod

  // register file
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] operand_q;
  logic [31:0] operand_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i;
  wire hit_ctrl = wb_adr_i == tmr_pkg::ADR_CTRL;
  wire hit_operand = wb_adr_i == tmr_pkg::ADR_OPERAND;
  wire hit_product = wb_adr_i == tmr_pkg::ADR_PRODUCT;
  wire hit_status = wb_adr_i == tmr_pkg::ADR_STATUS;

  wire [L-1:0] pipe_en = ctrl_q[tmr_pkg::CTRL_PIPE_LSB +: L];
  wire mult_mode = ctrl_q[tmr_pkg::CTRL_MULT_BIT];
  wire fast_sel = ctrl_q[tmr_pkg::CTRL_FAST_BIT];
  wire inv_mode = ctrl_q[tmr_pkg::CTRL_INV_BIT];

  // operand path: fast line straight into the cells, bypassing local routing
  wire fast_feed = mult_mode & fast_sel;
  wire [15:0] op_a = fast_feed ? fast_line_a : operand_q[15:0];
  wire [15:0] op_b = fast_feed ? fast_line_b : operand_q[tmr_pkg::OPB_LSB +: 16];

  // in multiplier mode the group secondary enable and preset lines drive partial-sum generation,
  // not the register enables or presets
  wire pp_gate = mult_mode ? (group_clock_enable_secondary & ~group_preset_or_async_load) : 1'b1;
  wire cell_cke = mult_mode ? 1'b1 : group_clock_enable_secondary;
  wire cell_pre = mult_mode ? 1'b0 : group_preset_or_async_load;

  logic [N-1:0][W-1:0] comb_l [L];
  logic [N-1:0][W-1:0] reg_l [L];
  logic [N-1:0][W-1:0] sel_l [L];
  logic [W-1:0] product_q;

  genvar gl;
  genvar gi;
  generate
    for (gl = 0; gl < L; gl++) begin : g_lvl
      for (gi = 0; gi < N; gi++) begin : g_node
        if (gi < (N >> gl)) begin : g_used
          if (gl == 0) begin : g_first
            // partial product pair formed and summed in one stage
            assign comb_l[0][gi] = pp_gate ? (part_prod(op_a, op_b, 2 * gi)
                                              + part_prod(op_a, op_b, 2 * gi + 1)) : '0;
          end else begin : g_sum
            assign comb_l[gl][gi] = sel_l[gl-1][2 * gi] + sel_l[gl-1][2 * gi + 1];
          end
        end else begin : g_idle
          assign comb_l[gl][gi] = '0;
        end
      end
      tmr_cell_reg #(.WIDTH(tmr_pkg::LVL_W), .CHIP_RESET_EN(CHIP_RESET_EN)) u_stage (
        .clk(clk),
        .srst(srst),
        .cke(cell_cke),
        .group_clear(group_clear),
        .group_preset(cell_pre),
        .chip_reset_n(chip_wide_reset_n),
        .inv_mode(inv_mode),
        .d(comb_l[gl]),
        .q(reg_l[gl])
      );
      assign sel_l[gl] = pipe_en[gl] ? reg_l[gl] : comb_l[gl];
    end
  endgenerate

  // four adder levels reach the product, one fewer than the reference tree
  tmr_cell_reg #(.WIDTH(W), .CHIP_RESET_EN(CHIP_RESET_EN)) u_product (
    .clk(clk),
    .srst(srst),
    .cke(cell_cke),
    .group_clear(group_clear),
    .group_preset(cell_pre),
    .chip_reset_n(chip_wide_reset_n),
    .inv_mode(inv_mode),
    .d(sel_l[L-1][0]),
    .q(product_q)
  );

  assign product_fast = product_q;
  assign product_local = fast_sel ? '0 : product_q;

  // latency in clocks from operand change to product register
  logic [3:0] latency;
  always_comb begin
    latency = 4'h1;
    for (int k = 0; k < L; k++) begin
      latency = latency + {3'h0, pipe_en[k]};
    end
  end

  wire [31:0] status_word = {21'h000000, !chip_wide_reset_n, group_preset_or_async_load,
                             group_clear, 4'h0, latency};

  assign ctrl_d = (wr & hit_ctrl) ? byte_merge(ctrl_q, wb_dat_i, wb_sel_i) : ctrl_q;
  assign operand_d = (wr & hit_operand) ? byte_merge(operand_q, wb_dat_i, wb_sel_i) : operand_q;
  assign ack_d = req;
  // unmapped addresses answer with zero and still ack
  assign dat_d = !(req & ~wb_we_i) ? dat_q :
                 hit_ctrl ? ctrl_q :
                 hit_operand ? operand_q :
                 hit_product ? product_q :
                 hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= tmr_pkg::CTRL_RESET;
      operand_q <= tmr_pkg::OPERAND_RESET;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      operand_q <= operand_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  wire [31:0] full_mul = {16'h0000, op_a} * {16'h0000, op_b};
  wire quiet_ctl = !group_clear && (!CHIP_RESET_EN || chip_wide_reset_n) && !inv_mode;

  a_bus_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in next cycle");
  a_tree_comb_result: assert property (pp_gate && pipe_en == '0 |-> sel_l[L-1][0] == full_mul)
    else $error("unpipelined tree does not give the product");
  a_prod_full_width: assert property (quiet_ctl && !cell_pre && cell_cke && pp_gate && pipe_en == '0
                                      |=> !(quiet_ctl && !cell_pre) || product_q == $past(full_mul))
    else $error("product register wrong or truncated");
  a_pipe_two_stage: assert property (quiet_ctl && !cell_pre && cell_cke && pipe_en == 4'h1
                                     ##1 quiet_ctl && !cell_pre && cell_cke && pipe_en == 4'h1
                                     |=> !(quiet_ctl && !cell_pre)
                                         || product_q == $past(sel_l[0][0] + sel_l[0][1] + sel_l[0][2]
                                         + sel_l[0][3] + sel_l[0][4] + sel_l[0][5] + sel_l[0][6]
                                         + sel_l[0][7]))
    else $error("registered stage does not feed the later tree");
  a_pp_group_gate: assert property (mult_mode && !group_clock_enable_secondary |-> comb_l[0] == '0)
    else $error("partial sums not gated by group enable");
  a_cke_ignored: assert property (mult_mode && !group_clock_enable_secondary && quiet_ctl
                                  |=> !quiet_ctl || reg_l[0] == $past(comb_l[0]))
    else $error("secondary enable stalled a multiplier-mode register");
  a_fast_direct: assert property (mult_mode && fast_sel |-> op_a == fast_line_a && op_b == fast_line_b)
    else $error("fast line operands not used directly");
  a_local_silent: assert property (fast_sel |-> product_local == '0)
    else $error("local output driven while fast output in use");
  a_clear_wins: assert property (group_clear && !inv_mode |-> product_q == '0)
    else $error("clear did not force zero");
  a_preset_ones: assert property (cell_pre && quiet_ctl |-> product_q == '1)
    else $error("preset did not force ones");
  a_preset_clears: assert property (cell_pre && inv_mode && !group_clear
                                    && (!CHIP_RESET_EN || chip_wide_reset_n) |-> product_q == '0)
    else $error("inverted preset did not clear the output");
  a_chip_reset: assert property (CHIP_RESET_EN && !chip_wide_reset_n && !inv_mode
                                 |-> product_q == '0 && reg_l[0] == '0)
    else $error("chip reset did not clear registers");

  c_full_pipe: cover property (pipe_en == 4'hF && mult_mode ##4 product_q != '0);
  c_fast_mode: cover property (fast_feed && group_clock_enable_secondary ##1 product_fast != '0);
  c_preset_clear: cover property (group_clear && group_preset_or_async_load && !mult_mode);
  c_bus_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == tmr_pkg::ADR_PRODUCT);
endmodule : tmr_tree_multiplier
`default_nettype wire

/* File: common/tmr_pkg.sv */
// constants for the tree multiplier datapath and its wishbone register file
// assumes one 40 MHz clock and a classic wishbone master with 32-bit data
//
// Contract
// - multiply 16-bit multiplicand by 16-bit multiplier
// - sixteen partial products, each multiplicand gated by bit
// - later stages add pairs until one product remains
// - conventional tree depth of five is the reference
// - partial products and first pair sum merged
// - each stage has registered and unregistered sum
// - secondary enable and preset steer partial sums
// - secondary enable never clock-enables multiplier-mode registers
// - fast line operands feed cells directly
// - fast output in use silences local output
// - true asynchronous clear and preset per register
// - clear beats preset when both asserted
// - one shared clear and preset per group
// - inverted storage makes preset act as clear
// - chip-wide active-low reset overrides every control
// - build option decides if chip reset acts
package tmr_pkg;
  localparam int OP_W = 16;
  localparam int PROD_W = 32;
  localparam int REF_STAGES = 5;
  localparam int TREE_STAGES = REF_STAGES - 1;
  localparam int NODES = 8;
  localparam int LVL_W = NODES * PROD_W;
  localparam int CLK_MHZ = 40;

  localparam int ADR_W = 4;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_OPERAND = 4'h4;
  localparam logic [3:0] ADR_PRODUCT = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hC;

  // control and operand register fields
  localparam int CTRL_PIPE_LSB = 0;
  localparam int CTRL_MULT_BIT = 4;
  localparam int CTRL_FAST_BIT = 5;
  localparam int CTRL_INV_BIT = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
  localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;
  localparam int OPB_LSB = 16;
  // status register fields
  localparam int STAT_LAT_LSB = 0;
  localparam int STAT_CLR_BIT = 8;
  localparam int STAT_PRE_BIT = 9;
  localparam int STAT_CHIP_BIT = 10;
endpackage : tmr_pkg

/* File: hdl/tmr_cell_reg.sv */
// one bank of logic-cell registers sharing a group clear and preset
// assumes clear, preset and chip reset are glitch-free group lines
`timescale 1ns/10ps
`default_nettype none
module tmr_cell_reg #(
  parameter int WIDTH = 32,
  parameter bit CHIP_RESET_EN = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cke,
  input wire logic group_clear,
  input wire logic group_preset,
  input wire logic chip_reset_n,
  input wire logic inv_mode,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] store_q;
  wire chip_hit = CHIP_RESET_EN && !chip_reset_n;
  // chip reset joins the clear path so it beats preset and clock
  wire clr_any = group_clear | chip_hit;
  wire pre_any = group_preset & ~clr_any;

  always_ff @(posedge clk or posedge clr_any or posedge pre_any) begin
    if (clr_any) begin
      store_q <= '0;
    end else if (pre_any) begin
      store_q <= '1;
    end else if (srst) begin
      store_q <= '0;
    end else if (cke) begin
      store_q <= inv_mode ? ~d : d;
    end
  end

  // inverted storage turns the all-ones preset into a zero output
  assign q = inv_mode ? ~store_q : store_q;
endmodule : tmr_cell_reg
`default_nettype wire

/* File: dv/tmr_user_model.sv */
// operand source standing in for the surrounding user logic
// assumes it shares the multiplier clock and drives the fast line only
`timescale 1ns/10ps
`default_nettype none
module tmr_user_model (
  input wire logic clk,
  input wire logic hold_en,
  input wire logic [15:0] a_in,
  input wire logic [15:0] b_in,
  output logic [15:0] fast_line_a,
  output logic [15:0] fast_line_b
);
  initial begin
    fast_line_a = 16'h0000;
    fast_line_b = 16'h0000;
  end
  // released lines toggle so a stale operand can never look valid
  always @(posedge clk) begin
    if (hold_en) begin
      fast_line_a <= a_in;
      fast_line_b <= b_in;
    end else begin
      fast_line_a <= ~fast_line_a;
      fast_line_b <= ~fast_line_b;
    end
  end
endmodule : tmr_user_model
`default_nettype wire

/* File: dv/testbench.sv */
// register-level bench for the tree multiplier, a second copy built without chip reset
// assumes the wishbone timing and the register map of the designer's note
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, gce = 1, gclr = 0, gpre = 0, crst_n = 1, hold = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, expv;
  logic [15:0] ua = 16'h0, ub = 16'h0, oa, ob;
  logic [3:0] pipes [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
  wire logic [31:0] dat_o, pf, pl, pf2;
  wire logic ack;
  wire logic [15:0] fa, fb;
  int n_fail = 0, checks = 0;
  tmr_tree_multiplier dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .fast_line_a(fa), .fast_line_b(fb), .group_clock_enable_secondary(gce), .group_clear(gclr),
    .group_preset_or_async_load(gpre), .chip_wide_reset_n(crst_n), .product_fast(pf), .product_local(pl));
  // copy with the chip reset option off shares every input
  tmr_tree_multiplier #(.CHIP_RESET_EN(1'b0)) dut_b (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(),
    .wb_ack_o(), .fast_line_a(fa), .fast_line_b(fb), .group_clock_enable_secondary(gce),
    .group_clear(gclr), .group_preset_or_async_load(gpre), .chip_wide_reset_n(crst_n),
    .product_fast(pf2), .product_local());
  tmr_user_model user (.clk(clk), .hold_en(hold), .a_in(ua), .b_in(ub), .fast_line_a(fa), .fast_line_b(fb));
  initial forever #12.5 clk = ~clk;
  task conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
    // ack and read data are taken at the edge that samples ack high, then the request drops
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    if (ack !== 1'b1) begin
      n_fail++;
      conclude();
    end
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  task rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rd
  task wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wt
  task setop(input logic [15:0] a, input logic [15:0] b);
    wb(1'b1, tmr_pkg::ADR_OPERAND, {b, a});
    oa = a; ob = b;
    wt(8);
  endtask : setop
  initial begin
    repeat (20) @(posedge clk);
    srst <= 0;
    rd(tmr_pkg::ADR_CTRL, tmr_pkg::CTRL_RESET);
    rd(tmr_pkg::ADR_OPERAND, tmr_pkg::OPERAND_RESET);
    rd(tmr_pkg::ADR_PRODUCT, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    setop(16'hFFFF, 16'hFFFF);
    rd(tmr_pkg::ADR_PRODUCT, 32'hFFFE_0001);
    foreach (pipes[i]) begin
      expv = {28'h0000000, pipes[i]};
      wb(1'b1, tmr_pkg::ADR_CTRL, 32'h10 | expv);
      rd(tmr_pkg::ADR_STATUS, 32'(1 + $countones(expv[3:0])));
      setop(16'h1234 + 16'(i), 16'hF00F ^ 16'(i * 16'h0411));
      `CHK(pf, 32'(oa) * 32'(ob))
    end
    wb(1'b1, tmr_pkg::ADR_CTRL, 32'h10);
    `CHK(pl, pf)
    @(posedge clk) begin hold <= 1; ua <= 16'hA5C3; ub <= 16'h8001; end
    wb(1'b1, tmr_pkg::ADR_CTRL, 32'h30);
    wt(8);
    `CHK(pf, 32'hA5C3 * 32'h8001)
    `CHK(pl, 32'h0)
    wb(1'b1, tmr_pkg::ADR_CTRL, 32'h10);
    @(posedge clk) gce <= 0;
    wt(8);
    `CHK(pf, 32'h0)
    @(posedge clk) begin gce <= 1; gpre <= 1; end
    wt(8);
    `CHK(pf, 32'h0)
    @(posedge clk) gpre <= 0;
    wb(1'b1, tmr_pkg::ADR_CTRL, 32'h00);
    setop(16'h0101, 16'h0303);
    @(posedge clk) gce <= 0;
    wb(1'b1, tmr_pkg::ADR_OPERAND, 32'h7777_7777);
    wt(8);
    `CHK(pf, 32'h0101 * 32'h0303)
    @(posedge clk) begin gce <= 1; gpre <= 1; end
    #2 `CHK(pf, 32'hFFFF_FFFF)
    @(posedge clk) gclr <= 1;
    #2 `CHK(pf, 32'h0)
    rd(tmr_pkg::ADR_STATUS, 32'h0000_0301);
    @(posedge clk) begin gclr <= 0; gpre <= 0; end
    wb(1'b1, tmr_pkg::ADR_CTRL, 32'h40);
    @(posedge clk) gpre <= 1;
    #2 `CHK(pf, 32'h0)
    @(posedge clk) begin gpre <= 0; gclr <= 1; end
    #2 `CHK(pf, 32'hFFFF_FFFF)
    @(posedge clk) gclr <= 0;
    wb(1'b1, tmr_pkg::ADR_CTRL, 32'h00);
    setop(16'h00FF, 16'h0010);
    @(posedge clk) begin gpre <= 1; crst_n <= 0; end
    #2 `CHK(pf, 32'h0)
    `CHK(pf2, 32'hFFFF_FFFF)
    @(posedge clk) begin gpre <= 0; crst_n <= 1; end
    wt(2);
    conclude();
  end
endmodule : testbench
`default_nettype wire
